/* design/mcp_control.sv */
// Notes on behaviour
// - vector select chooses application or boot base
// - boot base comes from size configuration
// - interrupts blocked through select plus one
// - without select write, block five cycles (write cycle plus four-cycle window)
// - global interrupt flag left untouched
// - change enable clears after four cycles
// - boot vectors plus app lock mute application
// - app vectors plus boot lock mute boot
// - detector off live after three, three long
// - sleep turns detector off only while live
// - pull-up disable kills every pull-up
// - register at data 0x55, io 0x35
// - implemented bits reset to zero
// - reset to boot starts at boot base
`timescale 1ns/1ps
`default_nettype none
module mcp_control
  import mcp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // core register access
  input  wire logic [7:0]  addr_i,
  input  wire logic        io_space_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o,
  // configuration and core status
  input  wire logic [1:0]  boot_size_config_i,
  input  wire logic        reset_to_boot_config_i,
  input  wire logic        app_side_boot_lock_i,
  input  wire logic        boot_side_boot_lock_i,
  input  wire logic        exec_in_boot_i,
  input  wire logic        sleep_exec_i,
  input  wire logic        instr_done_i,
  // controls
  output logic [15:0]      vector_base_o,
  output logic [15:0]      reset_vector_o,
  output logic             irq_block_o,
  output logic             pullup_disable_o,
  output logic             detector_off_o
);
  logic        hit;
  logic        wr_hit;
  logic        chg_open;
  logic        dse_open;
  logic        vsel_r,  vsel_nxt;
  logic        pud_r,   pud_nxt;
  logic        dse_r,   dse_nxt;
  logic        chg_set;
  logic        vsel_wr;
  logic        post_r,  post_nxt;
  logic        dse_arm;
  logic        dso_wr;
  mcp_ds_e     ds_r,    ds_nxt;
  logic [2:0]  dcnt_r,  dcnt_nxt;
  logic [15:0] boot_base;
  logic [7:0]  rdata_nxt;
  logic [15:0] vbase_nxt;
  logic [15:0] rvec_nxt;
  logic        blk_nxt;
  logic        doff_nxt;

  assign hit    = io_space_i ? (addr_i == MCP_IO_OFS) : (addr_i == MCP_DATA_OFS);
  assign wr_hit = wr_i && hit;
  assign chg_set = wr_hit && wdata_i[MCP_BIT_CHG];
  // a select write only counts inside the window and with change enable written zero
  assign vsel_wr = wr_hit && chg_open && !wdata_i[MCP_BIT_CHG];
  assign dse_arm = wr_hit && wdata_i[MCP_BIT_DSE] && wdata_i[MCP_BIT_DSO];
  assign dso_wr  = wr_hit && dse_open && !wdata_i[MCP_BIT_DSE]
                   && wdata_i[MCP_BIT_DSO];

  // change enable window; kill on select write
  mcp_window u_chg (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (chg_set),
    .kill_i  (vsel_wr),
    .len_i   (MCP_WIN_W),
    .open_o  (chg_open)
  );

  mcp_window u_dse (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .start_i (dse_arm),
    .kill_i  (dso_wr),
    .len_i   (MCP_WIN_W),
    .open_o  (dse_open)
  );

  always_comb begin
    vsel_nxt = vsel_r;
    pud_nxt  = pud_r;
    dse_nxt  = dse_r;
    post_nxt = post_r;
    if (vsel_wr) begin
      vsel_nxt = wdata_i[MCP_BIT_VSEL];
      post_nxt = 1'b1;
    end else if (post_r && instr_done_i) begin
      post_nxt = 1'b0;
    end
    if (wr_hit) begin
      pud_nxt = wdata_i[MCP_BIT_PUD];
      dse_nxt = wdata_i[MCP_BIT_DSE];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vsel_r <= MCP_RESET_VAL[MCP_BIT_VSEL];
      pud_r  <= MCP_RESET_VAL[MCP_BIT_PUD];
      dse_r  <= MCP_RESET_VAL[MCP_BIT_DSE];
      post_r <= 1'b0;
    end else begin
      vsel_r <= vsel_nxt;
      pud_r  <= pud_nxt;
      dse_r  <= dse_nxt;
      post_r <= post_nxt;
    end
  end

  // detector-off delay then live period
  always_comb begin
    ds_nxt   = ds_r;
    dcnt_nxt = dcnt_r;
    unique case (ds_r)
      MCP_DS_IDLE: begin
        if (dso_wr) begin
          ds_nxt   = MCP_DS_WAIT;
          dcnt_nxt = MCP_DLY_W - 3'h1;
        end
      end
      MCP_DS_WAIT: begin
        if (dcnt_r == 3'h0) begin
          ds_nxt   = MCP_DS_LIVE;
          dcnt_nxt = MCP_HOLD_W - 3'h1;
        end else begin
          dcnt_nxt = dcnt_r - 3'h1;
        end
      end
      MCP_DS_LIVE: begin
        if (dcnt_r == 3'h0) begin
          ds_nxt = MCP_DS_IDLE;
        end else begin
          dcnt_nxt = dcnt_r - 3'h1;
        end
      end
      default: begin
        ds_nxt   = MCP_DS_IDLE;
        dcnt_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ds_r   <= MCP_DS_IDLE;
      dcnt_r <= 3'h0;
    end else begin
      ds_r   <= ds_nxt;
      dcnt_r <= dcnt_nxt;
    end
  end

  // outputs, all registered
  always_comb begin
    unique case (boot_size_config_i)
      2'h0:    boot_base = MCP_BOOT_2K;
      2'h1:    boot_base = MCP_BOOT_1K;
      2'h2:    boot_base = MCP_BOOT_512;
      default: boot_base = MCP_BOOT_256;
    endcase
    rdata_nxt = 8'h00;
    if (rd_i && hit) begin
      rdata_nxt[MCP_BIT_DSO]  = (ds_r != MCP_DS_IDLE);
      rdata_nxt[MCP_BIT_DSE]  = dse_r;
      rdata_nxt[MCP_BIT_PUD]  = pud_r;
      rdata_nxt[MCP_BIT_VSEL] = vsel_r;
      rdata_nxt[MCP_BIT_CHG]  = chg_open;
    end
    vbase_nxt = vsel_nxt ? boot_base : MCP_APP_BASE;
    rvec_nxt  = reset_to_boot_config_i ? boot_base : MCP_APP_BASE;
    // block only gates servicing; the core's global flag is never written here
    blk_nxt = chg_set || chg_open || post_nxt
              || (vsel_nxt && app_side_boot_lock_i && !exec_in_boot_i)
              || (!vsel_nxt && boot_side_boot_lock_i && exec_in_boot_i);
    doff_nxt = sleep_exec_i && (ds_r == MCP_DS_LIVE);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o          <= 8'h00;
      vector_base_o    <= MCP_APP_BASE;
      reset_vector_o   <= MCP_APP_BASE;
      irq_block_o      <= 1'b0;
      pullup_disable_o <= 1'b0;
      detector_off_o   <= 1'b0;
    end else begin
      rdata_o          <= rdata_nxt & MCP_IMPL_MASK;
      vector_base_o    <= vbase_nxt;
      reset_vector_o   <= rvec_nxt;
      irq_block_o      <= blk_nxt;
      pullup_disable_o <= pud_nxt;
      detector_off_o   <= doff_nxt;
    end
  end

  // checks
  a_chg_blocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    chg_set |=> irq_block_o) else $error("change enable did not block");
  a_chg_expires: assert property (@(posedge clk_i) disable iff (!nrst_i)
    chg_set ##1 !wr_i [*4] |=> !chg_open)
    else $error("change window too long");
  a_vsel_guard: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!chg_open && wr_i) |=> $stable(vsel_r))
    else $error("select changed outside window");
  a_ds_delay: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (dso_wr && ds_r == MCP_DS_IDLE) |=> (ds_r == MCP_DS_WAIT) [*3] ##1 (ds_r == MCP_DS_LIVE) [*3]
    ##1 (ds_r == MCP_DS_IDLE)) else $error("detector off timing wrong");
  a_doff_live: assert property (@(posedge clk_i) disable iff (!nrst_i)
    detector_off_o |-> $past(ds_r) == MCP_DS_LIVE)
    else $error("detector off outside live");
  a_pud_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_hit |=> pullup_disable_o == $past(wdata_i[MCP_BIT_PUD]))
    else $error("pull-up disable not applied");
  a_vbase_sel: assert property (@(posedge clk_i) disable iff (!nrst_i)
    vector_base_o == (vsel_r ? boot_base : MCP_APP_BASE) || $changed(boot_size_config_i))
    else $error("vector base wrong");
  a_lock_mute: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (vsel_nxt && app_side_boot_lock_i && !exec_in_boot_i) |=> irq_block_o)
    else $error("locked app not muted");
  c_vsel_move: cover property (@(posedge clk_i) disable iff (!nrst_i)
    chg_set ##[1:4] vsel_wr);
  c_chg_lapse: cover property (@(posedge clk_i) disable iff (!nrst_i)
    chg_set ##1 chg_open [*4] ##1 !chg_open);
  c_doff: cover property (@(posedge clk_i) disable iff (!nrst_i) detector_off_o);
endmodule : mcp_control
`default_nettype wire

/* design/mcp_pkg.sv */
package mcp_pkg;

  // register location
  localparam logic [7:0] MCP_DATA_OFS   = 8'h55;
  localparam logic [7:0] MCP_IO_SHIFT   = 8'h20;
  localparam logic [7:0] MCP_IO_OFS     = MCP_DATA_OFS - MCP_IO_SHIFT;
  localparam logic [7:0] MCP_RESET_VAL  = 8'h00;

  // field positions
  localparam int MCP_BIT_CHG  = 0;
  localparam int MCP_BIT_VSEL = 1;
  localparam int MCP_BIT_PUD  = 4;
  localparam int MCP_BIT_DSE  = 5;
  localparam int MCP_BIT_DSO  = 6;
  localparam logic [7:0] MCP_IMPL_MASK = 8'h73;

  // timed windows, in clock cycles
  localparam int MCP_WIN_CYC    = 4;
  localparam int MCP_DSO_DLY    = 3;
  localparam int MCP_DSO_HOLD   = 3;
  localparam logic [2:0] MCP_WIN_W    = 3'h4;
  localparam logic [2:0] MCP_DLY_W    = 3'h3;
  localparam logic [2:0] MCP_HOLD_W   = 3'h3;

  // program memory (word addresses)
  localparam logic [15:0] MCP_APP_BASE = 16'h0000;
  localparam logic [1:0]  MCP_BSZ_2K   = 2'h0;
  localparam logic [15:0] MCP_BOOT_2K  = 16'h1C00;
  localparam logic [15:0] MCP_BOOT_1K  = 16'h1E00;
  localparam logic [15:0] MCP_BOOT_512 = 16'h1F00;
  localparam logic [15:0] MCP_BOOT_256 = 16'h1F80;

  typedef enum logic [2:0] {
    MCP_DS_IDLE = 3'h1,
    MCP_DS_WAIT = 3'h2,
    MCP_DS_LIVE = 3'h4
  } mcp_ds_e;

endpackage : mcp_pkg

/* design/mcp_window.sv */
`timescale 1ns/1ps
`default_nettype none
// down-counting timed window
module mcp_window
  import mcp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic       kill_i,
  input  wire logic [2:0] len_i,
  output logic            open_o
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start_i) begin
      cnt_nxt = len_i;
    end else if (kill_i) begin
      cnt_nxt = 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign open_o = (cnt_r != 3'h0);
endmodule : mcp_window
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import mcp_pkg::*;
;
  logic        clk_i = 0, nrst_i = 0, io_space_i = 0, wr_i = 0, rd_i = 0;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rv;
  logic [1:0]  boot_size_config_i = 2'h0;
  logic        reset_to_boot_config_i = 1'b1, app_side_boot_lock_i = 0, boot_side_boot_lock_i = 0;
  logic        exec_in_boot_i = 0, sleep_exec_i = 0, instr_done_i = 0;
  logic [15:0] vector_base_o, reset_vector_o;
  logic        irq_block_o, pullup_disable_o, detector_off_o;
  int          num_errors = 0, checks_done = 0, n;
  int          exp_base;
  int          m_chg = 0, m_vsel = 0, m_pud = 0, m_cfg = 0;
  mcp_control mcp_control_inst (
    .clk_i                  (clk_i),
    .nrst_i                 (nrst_i),
    .addr_i                 (addr_i),
    .io_space_i             (io_space_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .wdata_i                (wdata_i),
    .rdata_o                (rdata_o),
    .boot_size_config_i     (boot_size_config_i),
    .reset_to_boot_config_i (reset_to_boot_config_i),
    .app_side_boot_lock_i   (app_side_boot_lock_i),
    .boot_side_boot_lock_i  (boot_side_boot_lock_i),
    .exec_in_boot_i         (exec_in_boot_i),
    .sleep_exec_i           (sleep_exec_i),
    .instr_done_i           (instr_done_i),
    .vector_base_o          (vector_base_o),
    .reset_vector_o         (reset_vector_o),
    .irq_block_o            (irq_block_o),
    .pullup_disable_o       (pullup_disable_o),
    .detector_off_o         (detector_off_o)
  );
  always #2 clk_i = ~clk_i;
  // boot base per size setting, worked out independently of the design
  function automatic int boot_base(int sz);
    case (sz)
      0: return 'h1C00;
      1: return 'h1E00;
      2: return 'h1F00;
      default: return 'h1F80;
    endcase
  endfunction : boot_base
  task automatic chk(string what, int exp, logic [15:0] got);
    checks_done++;
    if (got !== exp[15:0]) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp[15:0], got);
    end
  endtask : chk
  // strobe stays high so back-to-back writes need no gap
  task automatic wr(logic [7:0] d);
    io_space_i = 1'($urandom_range(1));
    addr_i     = io_space_i ? MCP_IO_OFS : MCP_DATA_OFS;
    wdata_i    = d;
    wr_i       = 1'b1;
    @(negedge clk_i);
  endtask : wr
  task automatic idle(int c);
    wr_i = 1'b0;
    repeat (c) @(negedge clk_i);
  endtask : idle
  task automatic rd(logic [7:0] a, logic io);
    wr_i = 1'b0;
    addr_i = a;
    io_space_i = io;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    rv = rdata_o;
    @(negedge clk_i);
  endtask : rd
  // reference model of the register, advanced on every clock from the rules alone
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      m_chg  <= 0;
      m_vsel <= 0;
      m_pud  <= 0;
    end else if (wr_i && addr_i == (io_space_i ? MCP_IO_OFS : MCP_DATA_OFS)) begin
      m_pud <= wdata_i[MCP_BIT_PUD];
      if (wdata_i[MCP_BIT_CHG]) begin
        m_chg <= MCP_WIN_CYC;
      end else if (m_chg > 0) begin
        m_vsel <= wdata_i[MCP_BIT_VSEL];
        m_chg  <= 0;
      end
    end else if (m_chg > 0) begin
      m_chg <= m_chg - 1;
    end
    m_cfg <= boot_size_config_i;
  end
  // model against design once per cycle, away from the launching edge
  always @(negedge clk_i) begin
    if (nrst_i) begin
      chk("model pud", m_pud, pullup_disable_o);
      chk("model base", m_vsel ? boot_base(m_cfg) : 0, vector_base_o);
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // count detector-off cycles while sleep is held across the whole window
  task automatic sleep_span();
    n = 0;
    sleep_exec_i = 1'b1;
    repeat (10) begin
      @(negedge clk_i);
      if (detector_off_o === 1'b1) n++;
    end
    sleep_exec_i = 1'b0;
  endtask : sleep_span
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32));
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    idle(2);
    rd(MCP_DATA_OFS, 1'b0); chk("reset data", 0, rv);
    rd(MCP_IO_OFS, 1'b1); chk("io read", 0, rv);
    rd(8'h56, 1'b0); chk("unmapped", 0, rv);
    chk("reset vector", 'h1C00, reset_vector_o);
    chk("app base", 0, vector_base_o);
    $display("test reset done");
    wr(8'h10); idle(1);
    chk("pullup off", 1, pullup_disable_o);
    rd(MCP_IO_OFS, 1'b1); chk("pud read", 'h10, rv);
    wr(8'h00); idle(1);
    chk("pullup on", 0, pullup_disable_o);
    $display("test pullup done");
    repeat (4) begin
      boot_size_config_i = 2'($urandom_range(3));
      exp_base = boot_base(boot_size_config_i);
      wr(8'h01);
      chk("block on", 1, irq_block_o);
      wr(8'h02); idle(3);
      chk("boot base", exp_base, vector_base_o);
      chk("reset vector", exp_base, reset_vector_o);
      chk("block held", 1, irq_block_o);
      instr_done_i = 1'b1;
      @(negedge clk_i);
      instr_done_i = 1'b0;
      idle(2);
      chk("block freed", 0, irq_block_o);
      wr(8'h01); wr(8'h00); idle(1);
      chk("app again", 0, vector_base_o);
      instr_done_i = 1'b1;
      idle(3);
      instr_done_i = 1'b0;
    end
    $display("test vector move done");
    wr(8'h01);
    rd(MCP_DATA_OFS, 1'b0); chk("chg open", 'h01, rv);
    idle(6);
    chk("block timeout", 0, irq_block_o);
    rd(MCP_DATA_OFS, 1'b0); chk("chg cleared", 0, rv);
    wr(8'h02); idle(2);
    chk("late select", 0, vector_base_o);
    $display("test window done");
    sleep_span(); chk("no arm", 0, n);
    wr(8'h40); idle(1);
    sleep_span(); chk("bad arm", 0, n);
    wr(8'h60);
    rd(MCP_IO_OFS, 1'b1); chk("arm read", 'h20, rv);
    wr(8'h40); idle(0);
    sleep_span(); chk("armed off", MCP_DSO_HOLD, n);
    sleep_span(); chk("auto clear", 0, n);
    $display("test detector done");
    exp_base = boot_base(boot_size_config_i);
    wr(8'h01); wr(8'h02);
    instr_done_i = 1'b1;
    idle(3);
    instr_done_i = 1'b0;
    chk("lock base", exp_base, vector_base_o);
    app_side_boot_lock_i = 1'b1;
    idle(2); chk("app muted", 1, irq_block_o);
    exec_in_boot_i = 1'b1;
    idle(2); chk("boot live", 0, irq_block_o);
    app_side_boot_lock_i = 1'b0;
    wr(8'h01); wr(8'h00);
    instr_done_i = 1'b1;
    idle(3);
    instr_done_i = 1'b0;
    boot_side_boot_lock_i = 1'b1;
    idle(2); chk("boot muted", 1, irq_block_o);
    exec_in_boot_i = 1'b0;
    idle(2); chk("app live", 0, irq_block_o);
    reset_to_boot_config_i = 1'b0;
    idle(2); chk("app reset", 0, reset_vector_o);
    $display("test locks done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
